/* File: dv/vcc_top_properties.sv */
// Purpose: bus, tick and run checks for the calibration bank
// Assumes: one clock, sync reset active high, index = adr[9:2]
// Notes:   sees only the top ports
`timescale 1ns/100ps
module vcc_top_properties (
  input wire logic        SYS_CLK_IN,
  input wire logic        SRST_IN,
  input wire logic        WB_CYC_IN,
  input wire logic        WB_STB_IN,
  input wire logic        WB_WE_IN,
  input wire logic [31:0] WB_ADR_IN,
  input wire logic [3:0]  WB_SEL_IN,
  input wire logic [31:0] WB_DAT_IN,
  input wire logic [31:0] WB_DAT_OUT,
  input wire logic        WB_ACK_OUT,
  input wire logic        WB_ERR_OUT,
  input wire logic        US_TICK_OUT,
  input wire logic [2:0]  CAL_BUSY_OUT,
  input wire logic [4:0]  BIAS_SETTING_OUT,
  input wire logic [9:0]  RF_REF_COUNT_OUT,
  input wire logic [4:0]  IF_LOOP_CURRENT_OUT
);
  logic [7:0] idx;
  logic       wr_ack;
  logic       rd_ack;
  logic       req;
  logic [7:0] div_ff;
  logic [7:0] gap_ff;
  logic       gap_ok_ff;
  assign idx    = WB_ADR_IN[9:2];
  assign wr_ack = WB_ACK_OUT & WB_WE_IN & WB_SEL_IN[0];
  assign rd_ack = WB_ACK_OUT & ~WB_WE_IN;
  assign req    = WB_CYC_IN & WB_STB_IN;
  default clocking @(posedge SYS_CLK_IN); endclocking
  default disable iff (SRST_IN);
  // tracks divisor and clocks between ticks
  always_ff @(posedge SYS_CLK_IN) begin
    if (SRST_IN) begin
      div_ff    <= 8'h14;
      gap_ok_ff <= 1'b0;
      gap_ff    <= 8'h00;
    end else begin
      if (wr_ack && idx == 8'h50 && WB_SEL_IN[1]) begin
        div_ff    <= WB_DAT_IN[15:8];
        gap_ok_ff <= 1'b0;
      end else if (US_TICK_OUT) begin
        gap_ok_ff <= 1'b1;
      end
      gap_ff <= US_TICK_OUT ? 8'h01 : gap_ff + 8'h01;
    end
  end
  tick_period_a: assert property (US_TICK_OUT && gap_ok_ff |->
    gap_ff == ((div_ff == 8'h00) ? 8'h01 : div_ff))
    else $error("tick spacing differs from divisor");
  ack_timing_a: assert property ($rose(WB_STB_IN) && req |=>
    WB_ACK_OUT || WB_ERR_OUT) else $error("request not answered");
  ack_pulse_a: assert property (WB_ACK_OUT |=> !WB_ACK_OUT)
    else $error("ack longer than one cycle");
  unmapped_err_a: assert property ($rose(WB_STB_IN) && req &&
    idx == 8'h00 |=> WB_ERR_OUT && !WB_ACK_OUT)
    else $error("unmapped access not refused");
  for (genvar i = 0; i < 3; i++) begin : g_go
    go_starts_a: assert property (wr_ack && idx == 8'h50 &&
      WB_DAT_IN[i] && !$past(CAL_BUSY_OUT[i]) |-> CAL_BUSY_OUT[i])
      else $error("start bit did not launch a run");
  end
  zero_go_a: assert property (wr_ack && idx == 8'h50 &&
    WB_DAT_IN[2:0] == 3'h0 && CAL_BUSY_OUT == 3'h0 |=> CAL_BUSY_OUT == 3'h0 [*3])
    else $error("zero start bits launched a run");
  bias_write_a: assert property (wr_ack && idx == 8'h51 &&
    !CAL_BUSY_OUT[0] |=> BIAS_SETTING_OUT == $past(WB_DAT_IN[4:0]))
    else $error("bias setting not loaded");
  bias_read_a: assert property (rd_ack && idx == 8'h5b &&
    !CAL_BUSY_OUT[0] |-> WB_DAT_OUT == {27'h0, BIAS_SETTING_OUT})
    else $error("bias readback wrong");
  loop_read_a: assert property (rd_ack && idx == 8'hce |->
    WB_DAT_OUT == {24'h0, IF_LOOP_CURRENT_OUT[4], 3'h0,
    IF_LOOP_CURRENT_OUT[3:0]}) else $error("loop current readback wrong");
  ref_write_a: assert property (wr_ack && idx == 8'h54 &&
    WB_SEL_IN[1] |=> RF_REF_COUNT_OUT == $past(WB_DAT_IN[9:0]))
    else $error("reference count not loaded");
endmodule : vcc_top_properties

bind vcc_top vcc_top_properties u_props (
  .SYS_CLK_IN(SYS_CLK_IN), .SRST_IN(SRST_IN), .WB_CYC_IN(WB_CYC_IN),
  .WB_STB_IN(WB_STB_IN), .WB_WE_IN(WB_WE_IN), .WB_ADR_IN(WB_ADR_IN),
  .WB_SEL_IN(WB_SEL_IN), .WB_DAT_IN(WB_DAT_IN), .WB_DAT_OUT(WB_DAT_OUT),
  .WB_ACK_OUT(WB_ACK_OUT), .WB_ERR_OUT(WB_ERR_OUT),
  .US_TICK_OUT(US_TICK_OUT), .CAL_BUSY_OUT(CAL_BUSY_OUT),
  .BIAS_SETTING_OUT(BIAS_SETTING_OUT), .RF_REF_COUNT_OUT(RF_REF_COUNT_OUT),
  .IF_LOOP_CURRENT_OUT(IF_LOOP_CURRENT_OUT));

/* File: dv/vcc_top_tb.sv */
// Purpose: random and corner tests of the calibration bank
// Assumes: divisor 1 gives one tick a clock
// Notes:   run lengths come from default timing fields, the last two runs from programmed ones
`timescale 1ns/100ps
`define CHK(n, x, g) begin compares++; if ((g) !== (x)) begin errors++; \
  $display("ERROR %s expected %h seen %h", n, x, g); end end
module vcc_top_tb;
  logic        clk;
  logic        srst;
  logic        cyc;
  logic        stb;
  logic        we;
  logic [31:0] adr;
  logic [3:0]  sel;
  logic [31:0] wdat;
  logic [31:0] rdat;
  logic        ack;
  logic        err;
  logic        irq;
  logic        tick;
  logic [2:0]  busy;
  logic [4:0]  bias;
  logic [8:0]  rf_code;
  logic [8:0]  if_code;
  logic [9:0]  rf_ref;
  logic [9:0]  if_ref;
  logic [4:0]  loop_cur;
  logic [31:0] q;
  logic [31:0] r;
  logic        e;
  int          errors = 0;
  int          compares = 0;
  int          seed = 37421;
  int          tk = 0;
  int          runs[3] = '{8, 452, 533};

  vcc_top u_dut (
    .SYS_CLK_IN(clk), .SRST_IN(srst), .WB_CYC_IN(cyc), .WB_STB_IN(stb),
    .WB_WE_IN(we), .WB_ADR_IN(adr), .WB_SEL_IN(sel), .WB_DAT_IN(wdat),
    .WB_DAT_OUT(rdat), .WB_ACK_OUT(ack), .WB_ERR_OUT(err), .IRQ_OUT(irq),
    .US_TICK_OUT(tick), .CAL_BUSY_OUT(busy), .BIAS_SETTING_OUT(bias),
    .RF_CODE_OUT(rf_code), .IF_CODE_OUT(if_code),
    .RF_REF_COUNT_OUT(rf_ref), .IF_REF_COUNT_OUT(if_ref),
    .IF_LOOP_CURRENT_OUT(loop_cur));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) tk <= tk + 1;

  task automatic conclude();
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : conclude

  task automatic wb(input logic w, input logic [7:0] ix,
                    input logic [31:0] d, input logic [3:0] s);
    int n;
    n = 0;
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= {22'h0, ix, 2'b00};
    wdat <= d;
    sel  <= s;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && err !== 1'b1 && n < 40);
    `CHK("bus_answer", 1'b1, 1'(n < 40))
    q = rdat;
    e = err;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
  endtask : wb

  task automatic gap(input int x);
    int n;
    for (int k = 0; k < 2; k++) begin
      n = 0;
      do begin
        @(posedge clk);
        n++;
      end while (tick !== 1'b1 && n < 300);
    end
    `CHK("tick_gap", x, n)
  endtask : gap

  task automatic run(input int i, input int x);
    int t0;
    int n;
    t0 = tk;
    n = 0;
    wb(1'b1, 8'h50, 32'h0100 | (32'h1 << i), 4'hf);
    @(posedge clk);
    `CHK("busy", 3'(1 << i), busy)
    if (x > 50) begin
      wb(1'b1, 8'h50, 32'h0100, 4'hf);
      `CHK("busy_hold", 3'(1 << i), busy)
      wb(1'b0, 8'h5e, 32'h0, 4'hf);
      `CHK("progress", 32'h1 << i, q)
    end
    while (busy !== 3'h0 && n < 2000) begin
      @(posedge clk);
      n++;
    end
    @(posedge clk);
    `CHK("run_len", 1'b1, 1'(tk-t0 >= x && tk-t0 <= x+6))
  endtask : run

  initial begin
    #200000;
    errors++;
    $display("ERROR watchdog expected done seen hang");
    conclude();
  end

  initial begin
    {cyc, stb, we, adr, sel, wdat} = '0;
    srst = 1'b1;
    repeat (5) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    `CHK("rf_ref", 10'h15e, rf_ref)
    `CHK("if_ref", 10'h1c2, if_ref)
    `CHK("busy", 3'h0, busy)
    wb(1'b0, 8'h5b, 32'h0, 4'hf);
    `CHK("bias_rd", 32'h0, q)
    wb(1'b0, 8'h00, 32'h0, 4'hf);
    `CHK("unmapped", 1'b1, e)
    gap(20);
    $display("test reset done");
    for (int k = 0; k < 3; k++) begin
      r = 32'h2 + ($random(seed) & 32'hf);
      wb(1'b1, 8'h50, r << 8, 4'hf);
      gap(r);
    end
    wb(1'b1, 8'h50, 32'h0100, 4'hf);
    gap(1);
    `CHK("no_go", 3'h0, busy)
    $display("test divisor done");
    for (int k = 0; k < 4; k++) begin
      r = $random(seed);
      wb(1'b1, 8'h51, r & 32'h1f, 4'hf);
      wb(1'b1, 8'h51, ~r & 32'h1f, 4'he);
      `CHK("bias", r[4:0], bias)
      wb(1'b0, 8'h5b, 32'h0, 4'hf);
      `CHK("bias_rd", r & 32'h1f, q)
      wb(1'b1, 8'h54, r & 32'h3ff, 4'hf);
      wb(1'b1, 8'h58, r[25:16], 4'hf);
      `CHK("rf_ref", r[9:0], rf_ref)
      `CHK("if_ref", r[25:16], if_ref)
      wb(1'b1, 8'h53, r & 32'h1ff, 4'hf);
      wb(1'b1, 8'h57, r[24:16], 4'hf);
      `CHK("rf_code", r[8:0], rf_code)
      `CHK("if_code", r[24:16], if_code)
      wb(1'b0, 8'h5c, 32'h0, 4'hf);
      `CHK("rf_code_rd", r & 32'h1ff, q)
      wb(1'b0, 8'h5d, 32'h0, 4'hf);
      `CHK("if_code_rd", {23'h0, r[24:16]}, q)
      wb(1'b1, 8'h3e, r & 32'h8f, 4'hf);
      wb(1'b0, 8'hce, 32'h0, 4'hf);
      `CHK("loop_cur", {r[7], r[3:0]}, loop_cur)
      `CHK("loop_rd", r & 32'h8f, q)
    end
    $display("test registers done");
    wb(1'b1, 8'he1, 32'h7, 4'hf);
    for (int i = 0; i < 3; i++) begin
      run(i, runs[i]);
      `CHK("irq", 1'b1, irq)
      wb(1'b0, 8'he0, 32'h0, 4'hf);
      `CHK("status", 32'h1 << i, q)
      wb(1'b1, 8'he0, 32'h1 << i, 4'hf);
      `CHK("irq_clr", 1'b0, irq)
    end
    $display("test default runs done");
    wb(1'b1, 8'he1, 32'h0, 4'hf);
    wb(1'b1, 8'h52, 32'h9, 4'hf);
    run(0, 11);
    `CHK("irq_masked", 1'b0, irq)
    wb(1'b1, 8'he1, 32'h1, 4'hf);
    `CHK("irq_unmask", 1'b1, irq)
    wb(1'b1, 8'he0, 32'h1, 4'hf);
    `CHK("irq_clr", 1'b0, irq)
    wb(1'b1, 8'h56, 32'ha, 4'hf);
    wb(1'b1, 8'h55, 32'h0102, 4'hf);
    run(1, 34);
    $display("test programmed runs done");
    conclude();
  end
endmodule : vcc_top_tb

/* File: hdl/vcc_pkg.sv */
// Purpose: constants and types for the oscillator calibration register bank
// Assumes: classic wishbone, 32-bit data, byte address = 4 * index
// Notes:   offsets below are register indices
package vcc_pkg;

  localparam int unsigned CLK_MHZ = 100;

  // register indices
  localparam logic [7:0] IDX_CAL_CONTROL    = 8'h50;
  localparam logic [7:0] IDX_BIAS_WRITE     = 8'h51;
  localparam logic [7:0] IDX_BIAS_SETTLE    = 8'h52;
  localparam logic [7:0] IDX_RF_CODE_WRITE  = 8'h53;
  localparam logic [7:0] IDX_RF_REF_COUNT   = 8'h54;
  localparam logic [7:0] IDX_RF_SETTLE      = 8'h55;
  localparam logic [7:0] IDX_RF_STARTUP     = 8'h56;
  localparam logic [7:0] IDX_IF_CODE_WRITE  = 8'h57;
  localparam logic [7:0] IDX_IF_REF_COUNT   = 8'h58;
  localparam logic [7:0] IDX_IF_SETTLE      = 8'h59;
  localparam logic [7:0] IDX_IF_STARTUP     = 8'h5a;
  localparam logic [7:0] IDX_BIAS_READBACK  = 8'h5b;
  localparam logic [7:0] IDX_RF_CODE_READ   = 8'h5c;
  localparam logic [7:0] IDX_IF_CODE_READ   = 8'h5d;
  localparam logic [7:0] IDX_PROGRESS       = 8'h5e;
  localparam logic [7:0] IDX_IF_LOOP_CUR    = 8'h3e;
  localparam logic [7:0] IDX_IF_LOOP_CUR_RD = 8'hce;
  localparam logic [7:0] IDX_IRQ_STATUS     = 8'he0;
  localparam logic [7:0] IDX_IRQ_MASK       = 8'he1;

  // reset values
  localparam logic [7:0]  RST_TICK_DIV      = 8'h14;
  localparam logic [4:0]  RST_BIAS          = 5'h00;
  localparam logic [5:0]  RST_BIAS_SETTLE   = 6'h06;
  localparam logic [8:0]  RST_CODE          = 9'h000;
  localparam logic [9:0]  RST_RF_REF        = 10'h15e;
  localparam logic [15:0] RST_RF_SETTLE     = 16'h0d06;
  localparam logic [9:0]  RST_RF_STARTUP    = 10'h12c;
  localparam logic [9:0]  RST_IF_REF        = 10'h1c2;
  localparam logic [15:0] RST_IF_SETTLE     = 16'h0d0d;
  localparam logic [9:0]  RST_IF_STARTUP    = 10'h145;

  // field positions
  localparam int unsigned POS_IF_GO   = 2;
  localparam int unsigned POS_RF_GO   = 1;
  localparam int unsigned POS_BIAS_GO = 0;
  localparam int unsigned POS_HI_CUR  = 7;
  localparam int unsigned SETTLE_UNIT_SHIFT = 3; // units of 8 us

  // a calibration run's timing in microsecond ticks
  typedef struct packed {
    logic [15:0] start_wait;
    logic [15:0] settle_open;
    logic [15:0] settle_closed;
  } vcc_run_times_s;

  typedef enum logic [1:0] {
    PH_IDLE,
    PH_START,
    PH_OPEN,
    PH_CLOSED
  } vcc_phase_e;

endpackage : vcc_pkg

/* File: hdl/vcc_top.sv */
// Purpose: oscillator calibration register bank and run sequencer
// Assumes: classic wishbone slave, word-aligned, sync reset
// Notes:   analog comparators and search algorithm live outside
`timescale 1ns/100ps
module vcc_top (
  input  wire logic        SYS_CLK_IN,
  input  wire logic        SRST_IN,
  input  wire logic        WB_CYC_IN,
  input  wire logic        WB_STB_IN,
  input  wire logic        WB_WE_IN,
  input  wire logic [31:0] WB_ADR_IN,
  input  wire logic [3:0]  WB_SEL_IN,
  input  wire logic [31:0] WB_DAT_IN,
  output logic      [31:0] WB_DAT_OUT,
  output logic             WB_ACK_OUT,
  output logic             WB_ERR_OUT,
  output logic             IRQ_OUT,
  output logic             US_TICK_OUT,
  output logic      [2:0]  CAL_BUSY_OUT,
  output logic      [4:0]  BIAS_SETTING_OUT,
  output logic      [8:0]  RF_CODE_OUT,
  output logic      [8:0]  IF_CODE_OUT,
  output logic      [9:0]  RF_REF_COUNT_OUT,
  output logic      [9:0]  IF_REF_COUNT_OUT,
  output logic      [4:0]  IF_LOOP_CURRENT_OUT
);

  // bus decode
  logic        req;
  logic [7:0]  idx;
  logic        wr;
  logic        hit;
  logic        ack_ff;
  logic        err_ff;
  logic [31:0] rd_ff;
  logic [31:0] nxt_rd;
  logic        nxt_hit;

  // registers
  logic [7:0]  tick_divisor_mhz_ff;
  logic [4:0]  bias_ff;
  logic [5:0]  bias_settle_ff;
  logic [8:0]  rf_code_ff;
  logic [8:0]  if_code_ff;
  logic [9:0]  rf_ref_ff;
  logic [9:0]  if_ref_ff;
  logic [15:0] rf_settle_ff;
  logic [15:0] if_settle_ff;
  logic [9:0]  rf_startup_ff;
  logic [9:0]  if_startup_ff;
  logic        if_osc_high_current_ff;
  logic [3:0]  if_loop_current_ff;
  logic [2:0]  irq_stat_ff;
  logic [2:0]  irq_mask_ff;
  logic [2:0]  nxt_irq_stat;

  // timebase
  logic [7:0]  div_cnt_ff;
  logic        tick_ff;
  logic [7:0]  div_limit;

  // sequencers: 0 bias, 1 rf, 2 if
  vcc_pkg::vcc_phase_e phase_ff [3];
  logic [15:0] wait_ff [3];
  logic [2:0]  go;
  logic [2:0]  done;
  vcc_pkg::vcc_run_times_s times [3];

  function automatic logic [15:0] settle_us(input logic [7:0] units);
    settle_us = {5'h00, units, 3'h0};
  endfunction : settle_us

  // write strobe aimed at one register index
  function automatic logic wr_to(input logic [7:0] ix);
    wr_to = wr && idx == ix;
  endfunction : wr_to

  // countdown reaches its last tick
  function automatic logic last_tick(input logic [15:0] w);
    last_tick = w <= 16'h0001;
  endfunction : last_tick

  assign req = WB_CYC_IN && WB_STB_IN && !ack_ff && !err_ff;
  assign idx = WB_ADR_IN[9:2];
  assign wr  = req && WB_WE_IN && hit && WB_SEL_IN[0];

  always_comb begin
    nxt_hit = 1'b1;
    nxt_rd  = 32'h0000_0000;
    case (idx)
      vcc_pkg::IDX_CAL_CONTROL,
      vcc_pkg::IDX_BIAS_WRITE,
      vcc_pkg::IDX_BIAS_SETTLE,
      vcc_pkg::IDX_RF_CODE_WRITE,
      vcc_pkg::IDX_RF_REF_COUNT,
      vcc_pkg::IDX_RF_SETTLE,
      vcc_pkg::IDX_RF_STARTUP,
      vcc_pkg::IDX_IF_CODE_WRITE,
      vcc_pkg::IDX_IF_REF_COUNT,
      vcc_pkg::IDX_IF_SETTLE,
      vcc_pkg::IDX_IF_STARTUP,
      vcc_pkg::IDX_IF_LOOP_CUR: nxt_rd = 32'h0000_0000;
      vcc_pkg::IDX_BIAS_READBACK: begin
        nxt_rd = {27'h0000000, bias_ff};
      end
      vcc_pkg::IDX_RF_CODE_READ: begin
        nxt_rd = {23'h000000, rf_code_ff};
      end
      vcc_pkg::IDX_IF_CODE_READ: begin
        nxt_rd = {23'h000000, if_code_ff};
      end
      vcc_pkg::IDX_PROGRESS: begin
        nxt_rd = {29'h00000000, CAL_BUSY_OUT};
      end
      vcc_pkg::IDX_IF_LOOP_CUR_RD: begin
        nxt_rd = {24'h000000, if_osc_high_current_ff, 3'h0,
                  if_loop_current_ff};
      end
      vcc_pkg::IDX_IRQ_STATUS: begin
        nxt_rd = {29'h00000000, irq_stat_ff};
      end
      vcc_pkg::IDX_IRQ_MASK: begin
        nxt_rd = {29'h00000000, irq_mask_ff};
      end
      default: nxt_hit = 1'b0;
    endcase
  end
  assign hit = nxt_hit;

  // bus answer one cycle after request
  always_ff @(posedge SYS_CLK_IN) begin
    if (SRST_IN) begin
      ack_ff <= 1'b0;
      err_ff <= 1'b0;
      rd_ff  <= 32'h0000_0000;
    end else begin
      ack_ff <= req && hit;
      err_ff <= req && !hit;
      if (req && hit && !WB_WE_IN) begin
        rd_ff <= nxt_rd;
      end
    end
  end

  // configuration registers
  always_ff @(posedge SYS_CLK_IN) begin
    if (SRST_IN) begin
      tick_divisor_mhz_ff    <= vcc_pkg::RST_TICK_DIV;
      bias_settle_ff         <= vcc_pkg::RST_BIAS_SETTLE;
      rf_code_ff             <= vcc_pkg::RST_CODE;
      if_code_ff             <= vcc_pkg::RST_CODE;
      rf_ref_ff              <= vcc_pkg::RST_RF_REF;
      if_ref_ff              <= vcc_pkg::RST_IF_REF;
      rf_settle_ff           <= vcc_pkg::RST_RF_SETTLE;
      if_settle_ff           <= vcc_pkg::RST_IF_SETTLE;
      rf_startup_ff          <= vcc_pkg::RST_RF_STARTUP;
      if_startup_ff          <= vcc_pkg::RST_IF_STARTUP;
      if_osc_high_current_ff <= 1'b0;
      if_loop_current_ff     <= 4'h0;
      irq_mask_ff            <= 3'h0;
    end else if (wr) begin
      case (idx)
        vcc_pkg::IDX_CAL_CONTROL: begin
          if (WB_SEL_IN[1]) begin
            tick_divisor_mhz_ff <= WB_DAT_IN[15:8];
          end
        end
        vcc_pkg::IDX_BIAS_SETTLE: begin
          bias_settle_ff <= WB_DAT_IN[5:0];
        end
        vcc_pkg::IDX_RF_CODE_WRITE: begin
          if (WB_SEL_IN[1]) begin
            rf_code_ff <= WB_DAT_IN[8:0];
          end
        end
        vcc_pkg::IDX_IF_CODE_WRITE: begin
          if (WB_SEL_IN[1]) begin
            if_code_ff <= WB_DAT_IN[8:0];
          end
        end
        vcc_pkg::IDX_RF_REF_COUNT: begin
          if (WB_SEL_IN[1]) begin
            rf_ref_ff <= WB_DAT_IN[9:0];
          end
        end
        vcc_pkg::IDX_IF_REF_COUNT: begin
          if (WB_SEL_IN[1]) begin
            if_ref_ff <= WB_DAT_IN[9:0];
          end
        end
        vcc_pkg::IDX_RF_SETTLE: begin
          if (WB_SEL_IN[1]) begin
            rf_settle_ff <= WB_DAT_IN[15:0];
          end
        end
        vcc_pkg::IDX_IF_SETTLE: begin
          if (WB_SEL_IN[1]) begin
            if_settle_ff <= WB_DAT_IN[15:0];
          end
        end
        vcc_pkg::IDX_RF_STARTUP: begin
          if (WB_SEL_IN[1]) begin
            rf_startup_ff <= WB_DAT_IN[9:0];
          end
        end
        vcc_pkg::IDX_IF_STARTUP: begin
          if (WB_SEL_IN[1]) begin
            if_startup_ff <= WB_DAT_IN[9:0];
          end
        end
        vcc_pkg::IDX_IF_LOOP_CUR: begin
          if_osc_high_current_ff <= WB_DAT_IN[vcc_pkg::POS_HI_CUR];
          if_loop_current_ff     <= WB_DAT_IN[3:0];
        end
        vcc_pkg::IDX_IRQ_MASK: begin
          irq_mask_ff <= WB_DAT_IN[2:0];
        end
        default: ;
      endcase
    end
  end

  // bias setting: loaded by software only, the bias run does not change it
  always_ff @(posedge SYS_CLK_IN) begin
    if (SRST_IN) begin
      bias_ff <= vcc_pkg::RST_BIAS;
    end else if (wr_to(vcc_pkg::IDX_BIAS_WRITE)) begin
      bias_ff <= WB_DAT_IN[4:0];
    end
  end

  // start pulses, only on a one
  assign go[0] = wr && idx == vcc_pkg::IDX_CAL_CONTROL &&
                 WB_DAT_IN[vcc_pkg::POS_BIAS_GO];
  assign go[1] = wr && idx == vcc_pkg::IDX_CAL_CONTROL &&
                 WB_DAT_IN[vcc_pkg::POS_RF_GO];
  assign go[2] = wr && idx == vcc_pkg::IDX_CAL_CONTROL &&
                 WB_DAT_IN[vcc_pkg::POS_IF_GO];

  // divisor 0 counts as 1
  assign div_limit = (tick_divisor_mhz_ff == 8'h00) ? 8'h01 :
                     tick_divisor_mhz_ff;

  // microsecond timebase
  always_ff @(posedge SYS_CLK_IN) begin
    if (SRST_IN) begin
      div_cnt_ff <= 8'h00;
      tick_ff    <= 1'b0;
    end else if (div_cnt_ff + 8'h01 >= div_limit) begin
      div_cnt_ff <= 8'h00;
      tick_ff    <= 1'b1;
    end else begin
      div_cnt_ff <= div_cnt_ff + 8'h01;
      tick_ff    <= 1'b0;
    end
  end

  // per-run timing; bias run programs only its settle period, start and closed waits are one tick
  assign times[0] = '{start_wait: 16'h0001,
                      settle_open: {10'h000, bias_settle_ff},
                      settle_closed: 16'h0001};
  assign times[1] = '{start_wait: {6'h00, rf_startup_ff},
                      settle_open: settle_us(rf_settle_ff[15:8]),
                      settle_closed: settle_us(rf_settle_ff[7:0])};
  assign times[2] = '{start_wait: {6'h00, if_startup_ff},
                      settle_open: settle_us(if_settle_ff[15:8]),
                      settle_closed: settle_us(if_settle_ff[7:0])};

  generate
    for (genvar g = 0; g < 3; g++) begin : g_run
      assign done[g] = phase_ff[g] == vcc_pkg::PH_CLOSED &&
                       tick_ff && last_tick(wait_ff[g]);
      always_ff @(posedge SYS_CLK_IN) begin
        if (SRST_IN) begin
          phase_ff[g] <= vcc_pkg::PH_IDLE;
          wait_ff[g]  <= 16'h0000;
        end else begin
          case (phase_ff[g])
            vcc_pkg::PH_IDLE: begin
              if (go[g]) begin
                phase_ff[g] <= vcc_pkg::PH_START;
                wait_ff[g]  <= times[g].start_wait;
              end
            end
            vcc_pkg::PH_START: begin
              if (tick_ff) begin
                if (wait_ff[g] <= 16'h0001) begin
                  phase_ff[g] <= vcc_pkg::PH_OPEN;
                  wait_ff[g]  <= times[g].settle_open;
                end else begin
                  wait_ff[g] <= wait_ff[g] - 16'h0001;
                end
              end
            end
            vcc_pkg::PH_OPEN: begin
              if (tick_ff) begin
                if (wait_ff[g] <= 16'h0001) begin
                  phase_ff[g] <= vcc_pkg::PH_CLOSED;
                  wait_ff[g]  <= times[g].settle_closed;
                end else begin
                  wait_ff[g] <= wait_ff[g] - 16'h0001;
                end
              end
            end
            vcc_pkg::PH_CLOSED: begin
              if (tick_ff) begin
                if (wait_ff[g] <= 16'h0001) begin
                  phase_ff[g] <= vcc_pkg::PH_IDLE;
                end else begin
                  wait_ff[g] <= wait_ff[g] - 16'h0001;
                end
              end
            end
            default: phase_ff[g] <= vcc_pkg::PH_IDLE;
          endcase
        end
      end
      assign CAL_BUSY_OUT[g] =
        phase_ff[g] != vcc_pkg::PH_IDLE;
    end
  endgenerate

  // completion status: set wins over write-one-clear
  always_comb begin
    nxt_irq_stat = irq_stat_ff | done;
    if (wr_to(vcc_pkg::IDX_IRQ_STATUS)) begin
      nxt_irq_stat = (irq_stat_ff & ~WB_DAT_IN[2:0]) | done;
    end
  end

  always_ff @(posedge SYS_CLK_IN) begin
    if (SRST_IN) begin
      irq_stat_ff <= 3'h0;
    end else begin
      irq_stat_ff <= nxt_irq_stat;
    end
  end

  assign WB_DAT_OUT          = rd_ff;
  assign WB_ACK_OUT          = ack_ff;
  assign WB_ERR_OUT          = err_ff;
  assign IRQ_OUT             = |(irq_stat_ff & irq_mask_ff);
  assign US_TICK_OUT         = tick_ff;
  assign BIAS_SETTING_OUT    = bias_ff;
  assign RF_CODE_OUT         = rf_code_ff;
  assign IF_CODE_OUT         = if_code_ff;
  assign RF_REF_COUNT_OUT    = rf_ref_ff;
  assign IF_REF_COUNT_OUT    = if_ref_ff;
  assign IF_LOOP_CURRENT_OUT = {if_osc_high_current_ff, if_loop_current_ff};

endmodule : vcc_top
